// ### rtl/csd_params.svh
// address map, field positions, reset values and timing counts of the clock switch block
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define CSD_ADDR_W          8
`define CSD_ADDR_OSC_LO     8'h00
`define CSD_ADDR_OSC_HI     8'h01
`define CSD_ADDR_DIV        8'h02
`define CSD_ADDR_TRIM       8'h03

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSD_DIV_ROI         15
`define CSD_DIV_RATIO_HI    14
`define CSD_DIV_RATIO_LO    12
`define CSD_DIV_RATIO_EN    11
`define CSD_DIV_POST_HI     10
`define CSD_DIV_POST_LO     8
`define CSD_TRIM_HI         5
`define CSD_OSC_CUR_HI      14
`define CSD_OSC_CUR_LO      12
`define CSD_OSC_NEW_HI      10
`define CSD_OSC_NEW_LO      8
`define CSD_OSC_CLKLOCK     7
`define CSD_OSC_IOLOCK      6
`define CSD_OSC_LOCK        5
`define CSD_OSC_FAIL        3
`define CSD_OSC_PRIMARY_OSCILLATOR_SLP    2
`define CSD_OSC_SEC_EN      1
`define CSD_OSC_REQ         0
`define CSD_BYTE_SEL_HI     2
`define CSD_BYTE_SEL_LO     0

// ----------------------------------------------------------------
// keys, reset values, counts
// ----------------------------------------------------------------
`define CSD_KEY_HI_1        8'h78
`define CSD_KEY_HI_2        8'h9a
`define CSD_KEY_LO_1        8'h46
`define CSD_KEY_LO_2        8'h57
`define CSD_POST_RESET      3'h1
`define CSD_POST_DIV256     3'h7
`define CSD_SETTLE_CYCLES   4'ha
`define CSD_SYNC_W          12
`define CSD_INIT_WAIT       2'h3

`endif

// ### rtl/csd_pkg.sv
// types shared by the clock switch and divider block
package csd_pkg;

  // ----------------------------------------------------------------
  // oscillator source codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSD_SRC_FRC      = 3'b000,
    CSD_SRC_FRC_PLL  = 3'b001,
    CSD_SRC_PRI      = 3'b010,
    CSD_SRC_PRI_PLL  = 3'b011,
    CSD_SRC_SEC      = 3'b100,
    CSD_SRC_LOW_POWER_RC_OSCILLATOR     = 3'b101,
    CSD_SRC_RSVD     = 3'b110,
    CSD_SRC_FRC_POST = 3'b111
  } csd_src_type;

  // ----------------------------------------------------------------
  // switch sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSD_ST_IDLE    = 3'b000,
    CSD_ST_COMPARE = 3'b001,
    CSD_ST_WAIT    = 3'b010,
    CSD_ST_SETTLE  = 3'b011,
    CSD_ST_DONE    = 3'b100
  } csd_state_type;

  // ----------------------------------------------------------------
  // oscillator run enables
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fast_rc_oscillator;
    logic pll;
    logic primary;
    logic secondary;
    logic low_power_rc_oscillator;
  } csd_osc_en_type;

endpackage

// ### rtl/csd_pow2_div.sv
// divide-by-2^n enable pulse generator
`timescale 1ns/10ps
module csd_pow2_div
  import csd_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       arst_n_in,
  input  wire logic       tick_in,
  input  wire logic [2:0] sel_in,
  output logic            pulse_out
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] limit;
  logic       wrap;

  // limit is 2^n - 1, so code 000 passes every tick
  assign limit    = 8'((9'h001 << sel_in) - 9'h001);
  assign wrap     = cnt_reg >= limit;
  assign cnt_next = wrap ? 8'h00 : 8'(cnt_reg + 8'h01);

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg   <= 8'h00;
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= tick_in & wrap;
      if (tick_in) begin
        cnt_reg <= cnt_next;
      end
    end
  end

endmodule

// ### rtl/csd_clock_switch.sv
// clock ratio, fast rc postscale/trim and software oscillator switch sequencer
`timescale 1ns/10ps
`include "csd_params.svh"
module csd_clock_switch
  import csd_pkg::*;
(
  input  wire logic           clk_sys_in,
  input  wire logic           arst_n_in,
  input  wire logic [7:0]     addr_in,
  input  wire logic [15:0]    wdata_in,
  input  wire logic           wr_in,
  input  wire logic           rd_in,
  output logic      [15:0]    rdata_out,
  input  wire logic           irq_in,
  input  wire logic           switch_enable_config_in,
  input  wire logic           fail_monitor_config_in,
  input  wire logic [2:0]     reset_clock_select_config_in,
  input  wire logic [1:0]     primary_submode_config_in,
  input  wire logic           watchdog_enable_in,
  input  wire logic           start_up_timer_done_in,
  input  wire logic           pll_lock_in,
  input  wire logic           clock_fail_in,
  input  wire logic           new_src_clk_in,
  output csd_src_type         sys_src_sel_out,
  output csd_osc_en_type      osc_enable_out,
  output logic      [1:0]     primary_submode_out,
  output logic      [5:0]     fast_rc_trim_value_out,
  output logic                cpu_clk_en_out,
  output logic                fast_rc_post_tick_out,
  output logic                switch_busy_out
);

  // ----------------------------------------------------------------
  // needed oscillators per source code
  // ----------------------------------------------------------------
  function automatic csd_osc_en_type src_needs(input csd_src_type src);
    csd_osc_en_type en;
    en           = '0;
    en.fast_rc_oscillator       = (src == CSD_SRC_FRC) || (src == CSD_SRC_FRC_PLL) || (src == CSD_SRC_FRC_POST);
    en.pll       = (src == CSD_SRC_FRC_PLL) || (src == CSD_SRC_PRI_PLL);
    en.primary   = (src == CSD_SRC_PRI) || (src == CSD_SRC_PRI_PLL);
    en.secondary = (src == CSD_SRC_SEC);
    en.low_power_rc_oscillator      = (src == CSD_SRC_LOW_POWER_RC_OSCILLATOR);
    return en;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [`CSD_SYNC_W-1:0] sync1_reg;
  logic [`CSD_SYNC_W-1:0] sync2_reg;
  logic [`CSD_SYNC_W-1:0] pins_raw;
  logic                   new_clk_d_reg;

  assign pins_raw = {switch_enable_config_in, fail_monitor_config_in, watchdog_enable_in,
                     start_up_timer_done_in, pll_lock_in, clock_fail_in, new_src_clk_in,
                     reset_clock_select_config_in, primary_submode_config_in};

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_reg     <= '0;
      sync2_reg     <= '0;
      new_clk_d_reg <= 1'b0;
    end else begin
      sync1_reg     <= pins_raw;
      sync2_reg     <= sync1_reg;
      new_clk_d_reg <= sync2_reg[5];
    end
  end

  logic        sw_off_s;
  logic        clock_fail_monitor_cfg_s;
  logic        wdt_s;
  logic        ost_s;
  logic        pll_lock_s;
  logic        clk_fail_s;
  logic        new_clk_rise;
  csd_src_type rst_src_s;
  logic [1:0]  submode_s;
  logic        sw_allowed;
  logic        clock_fail_monitor_on;

  assign sw_off_s     = sync2_reg[11];
  assign clock_fail_monitor_cfg_s   = sync2_reg[10];
  assign wdt_s        = sync2_reg[9];
  assign ost_s        = sync2_reg[8];
  assign pll_lock_s   = sync2_reg[7];
  assign clk_fail_s   = sync2_reg[6];
  assign new_clk_rise = sync2_reg[5] & ~new_clk_d_reg;
  assign rst_src_s    = csd_src_type'(sync2_reg[4:2]);
  assign submode_s    = sync2_reg[1:0];
  assign sw_allowed   = ~sw_off_s;
  assign clock_fail_monitor_on      = ~sw_off_s & ~clock_fail_monitor_cfg_s;

  // ----------------------------------------------------------------
  // register bus decode and unlock keys
  // ----------------------------------------------------------------
  logic       wr_lo;
  logic       wr_hi;
  logic       wr_div;
  logic       wr_trim;
  logic       any_acc;
  logic [7:0] wbyte;
  logic [1:0] hi_key_reg;
  logic [1:0] hi_key_next;
  logic [1:0] lo_key_reg;
  logic [1:0] lo_key_next;
  logic       hi_ok;
  logic       lo_ok;

  assign wr_lo   = wr_in && (addr_in == `CSD_ADDR_OSC_LO);
  assign wr_hi   = wr_in && (addr_in == `CSD_ADDR_OSC_HI);
  assign wr_div  = wr_in && (addr_in == `CSD_ADDR_DIV);
  assign wr_trim = wr_in && (addr_in == `CSD_ADDR_TRIM);
  assign any_acc = wr_in | rd_in;
  assign wbyte   = wdata_in[7:0];
  assign hi_ok   = wr_hi && (hi_key_reg == `CSD_BYTE_SEL_HI);
  assign lo_ok   = wr_lo && (lo_key_reg == `CSD_BYTE_SEL_HI);

  // any access other than the next key step drops the unlock
  assign hi_key_next = !any_acc ? hi_key_reg :
                       (wr_hi && hi_key_reg == 2'h1 && wbyte == `CSD_KEY_HI_2) ? 2'h2 :
                       (wr_hi && hi_key_reg != 2'h2 && wbyte == `CSD_KEY_HI_1) ? 2'h1 :
                       2'h0;
  assign lo_key_next = !any_acc ? lo_key_reg :
                       (wr_lo && lo_key_reg == 2'h1 && wbyte == `CSD_KEY_LO_2) ? 2'h2 :
                       (wr_lo && lo_key_reg != 2'h2 && wbyte == `CSD_KEY_LO_1) ? 2'h1 :
                       2'h0;

  // ----------------------------------------------------------------
  // divider and trim registers
  // ----------------------------------------------------------------
  logic       roi_reg;
  logic [2:0] ratio_sel_reg;
  logic       ratio_en_reg;
  logic       ratio_en_next;
  logic [2:0] post_sel_reg;
  logic [5:0] trim_reg;
  logic [2:0] cpu_ratio;
  logic       post_half_reg;
  logic       post_tick;

  // recover-on-interrupt beats a same-cycle write setting the enable
  assign ratio_en_next = (roi_reg && irq_in) ? 1'b0 :
                         wr_div ? wdata_in[`CSD_DIV_RATIO_EN] : ratio_en_reg;
  assign cpu_ratio     = ratio_en_reg ? ratio_sel_reg : 3'h0;
  // code 111 divides by 256, not 128: halve the tick, reuse the 2^7 counter
  assign post_tick     = osc_enable_out.fast_rc_oscillator & ((post_sel_reg != `CSD_POST_DIV256) | post_half_reg);

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      roi_reg       <= 1'b0;
      ratio_sel_reg <= 3'h0;
      ratio_en_reg  <= 1'b0;
      post_sel_reg  <= `CSD_POST_RESET;
      trim_reg      <= 6'h00;
      post_half_reg <= 1'b0;
    end else begin
      ratio_en_reg  <= ratio_en_next;
      post_half_reg <= osc_enable_out.fast_rc_oscillator & ~post_half_reg;
      if (wr_div) begin
        roi_reg       <= wdata_in[`CSD_DIV_ROI];
        ratio_sel_reg <= wdata_in[`CSD_DIV_RATIO_HI:`CSD_DIV_RATIO_LO];
        post_sel_reg  <= wdata_in[`CSD_DIV_POST_HI:`CSD_DIV_POST_LO];
      end
      if (wr_trim) begin
        trim_reg <= wdata_in[`CSD_TRIM_HI:0];
      end
    end
  end

  csd_pow2_div u_cpu_div (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .tick_in    (1'b1),
    .sel_in     (cpu_ratio),
    .pulse_out  (cpu_clk_en_out)
  );

  // postscaler only advances while the fast rc is running
  csd_pow2_div u_post_div (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .tick_in    (post_tick),
    .sel_in     (post_sel_reg),
    .pulse_out  (fast_rc_post_tick_out)
  );

  // ----------------------------------------------------------------
  // oscillator control register and switch sequencer
  // ----------------------------------------------------------------
  csd_state_type state_reg;
  csd_state_type state_next;
  csd_src_type   cur_reg;
  csd_src_type   new_reg;
  csd_src_type   tgt_reg;
  logic          req_reg;
  logic          clklock_reg;
  logic          iolock_reg;
  logic          lock_reg;
  logic          fail_reg;
  logic          primary_oscillator_slp_reg;
  logic          sec_en_reg;
  logic [3:0]    settle_reg;
  logic [1:0]    init_reg;
  logic          init_done;
  logic          redundant;
  logic          src_ready;
  logic          settled;
  logic          req_set;
  logic          locked_out;
  csd_osc_en_type keep_en;

  assign init_done  = (init_reg == `CSD_INIT_WAIT);
  assign locked_out = clock_fail_monitor_on && clklock_reg;
  assign req_set    = lo_ok && wbyte[`CSD_OSC_REQ] && sw_allowed && !locked_out;
  // reserved code is treated like a redundant request
  assign redundant  = (new_reg == cur_reg) || (new_reg == CSD_SRC_RSVD);
  assign src_ready  = (!src_needs(tgt_reg).primary || ost_s) &&
                      (!src_needs(tgt_reg).pll || pll_lock_s);
  assign settled    = (settle_reg == `CSD_SETTLE_CYCLES);

  // old source always kept; low power rc added for watchdog or monitor, secondary for its enable
  always_comb begin
    keep_en           = src_needs(cur_reg);
    keep_en.low_power_rc_oscillator      = keep_en.low_power_rc_oscillator | wdt_s | clock_fail_monitor_on;
    keep_en.secondary = keep_en.secondary | sec_en_reg;
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CSD_ST_IDLE:    if (req_reg && sw_allowed) state_next = CSD_ST_COMPARE;
      CSD_ST_COMPARE: state_next = redundant ? CSD_ST_IDLE : CSD_ST_WAIT;
      CSD_ST_WAIT:    if (src_ready) state_next = CSD_ST_SETTLE;
      CSD_ST_SETTLE:  if (settled) state_next = CSD_ST_DONE;
      CSD_ST_DONE:    state_next = CSD_ST_IDLE;
      default:        state_next = CSD_ST_IDLE;
    endcase
  end

  // sequencer never gates the cpu enable: code runs throughout
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= CSD_ST_IDLE;
      settle_reg <= 4'h0;
      tgt_reg <= CSD_SRC_FRC_POST;
    end else begin
      state_reg <= state_next;
      if (state_reg == CSD_ST_COMPARE) begin
        tgt_reg <= new_reg;
      end
      if (state_reg != CSD_ST_SETTLE) begin
        settle_reg <= 4'h0;
      end else if (new_clk_rise && !settled) begin
        settle_reg <= 4'(settle_reg + 4'h1);
      end
    end
  end

  // config is caught once the synchronisers have filled after reset
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      init_reg            <= 2'h0;
      cur_reg             <= CSD_SRC_FRC_POST;
      new_reg             <= CSD_SRC_FRC_POST;
      primary_submode_out <= 2'h0;
    end else begin
      if (!init_done) begin
        init_reg <= 2'(init_reg + 2'h1);
      end
      if (init_reg == 2'h2) begin
        cur_reg             <= rst_src_s;
        new_reg             <= rst_src_s;
        primary_submode_out <= submode_s;
      end else if (init_done) begin
        if (hi_ok) begin
          new_reg <= csd_src_type'(wbyte[2:0]);
        end
        if (!sw_allowed) begin
          cur_reg <= rst_src_s;
        end else if (state_reg == CSD_ST_DONE) begin
          cur_reg <= tgt_reg;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_reg      <= 1'b0;
      clklock_reg  <= 1'b0;
      iolock_reg   <= 1'b0;
      primary_oscillator_slp_reg <= 1'b0;
      sec_en_reg   <= 1'b0;
    end else begin
      if (!sw_allowed) begin
        req_reg <= 1'b0;
      end else if (req_set) begin
        req_reg <= 1'b1;
      end else if ((state_reg == CSD_ST_COMPARE && redundant) || state_reg == CSD_ST_DONE) begin
        req_reg <= 1'b0;
      end
      if (lo_ok) begin
        clklock_reg  <= clklock_reg | wbyte[`CSD_OSC_CLKLOCK];
        iolock_reg   <= wbyte[`CSD_OSC_IOLOCK];
        primary_oscillator_slp_reg <= wbyte[`CSD_OSC_PRIMARY_OSCILLATOR_SLP];
        sec_en_reg   <= wbyte[`CSD_OSC_SEC_EN];
      end
    end
  end

  // fail flag: monitor event wins over a clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lock_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      if (state_reg == CSD_ST_COMPARE && !redundant) begin
        lock_reg <= 1'b0;
      end else begin
        lock_reg <= pll_lock_s && osc_enable_out.pll;
      end
      if (clock_fail_monitor_on && clk_fail_s) begin
        fail_reg <= 1'b1;
      end else if ((state_reg == CSD_ST_COMPARE && !redundant) ||
                   (lo_ok && !wbyte[`CSD_OSC_FAIL])) begin
        fail_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs and read data
  // ----------------------------------------------------------------
  logic [15:0] osc_word;
  logic [15:0] rd_mux;

  assign osc_word = {1'b0, cur_reg, 1'b0, new_reg, clklock_reg, iolock_reg, lock_reg, 1'b0,
                     fail_reg, primary_oscillator_slp_reg, sec_en_reg, req_reg & sw_allowed};
  assign rd_mux   = (addr_in == `CSD_ADDR_OSC_LO || addr_in == `CSD_ADDR_OSC_HI) ? osc_word :
                    (addr_in == `CSD_ADDR_DIV) ? {roi_reg, ratio_sel_reg, ratio_en_reg,
                                                  post_sel_reg, 8'h00} :
                    (addr_in == `CSD_ADDR_TRIM) ? {10'h000, trim_reg} :
                    16'h0000;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hi_key_reg             <= 2'h0;
      lo_key_reg             <= 2'h0;
      rdata_out              <= 16'h0000;
      sys_src_sel_out        <= CSD_SRC_FRC_POST;
      osc_enable_out         <= '0;
      fast_rc_trim_value_out <= 6'h00;
      switch_busy_out        <= 1'b0;
    end else begin
      hi_key_reg             <= hi_key_next;
      lo_key_reg             <= lo_key_next;
      rdata_out              <= rd_in ? rd_mux : 16'h0000;
      sys_src_sel_out        <= cur_reg;
      fast_rc_trim_value_out <= trim_reg;
      switch_busy_out        <= (state_reg != CSD_ST_IDLE);
      if (state_reg == CSD_ST_WAIT || state_reg == CSD_ST_SETTLE) begin
        osc_enable_out <= keep_en | src_needs(tgt_reg);
      end else if (init_done) begin
        osc_enable_out <= keep_en;
      end
    end
  end

endmodule

// ### verif/csd_switch_props.sv
// port checker for the clock switch block
`timescale 1ns/10ps
module csd_switch_props
  import csd_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        arst_n_in,
  input wire logic [7:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic        switch_enable_config_in,
  input csd_src_type      sys_src_sel_out,
  input csd_osc_en_type   osc_enable_out,
  input wire logic [1:0]  primary_submode_out,
  input wire logic [5:0]  fast_rc_trim_value_out,
  input wire logic        cpu_clk_en_out,
  input wire logic        fast_rc_post_tick_out,
  input wire logic        switch_busy_out
);
  // ----
  // gap counters and request history
  // ----
  logic [8:0] cpu_gap_reg;
  logic [8:0] post_gap_reg;
  logic [4:0] req_hist_reg;
  wire logic       req_wr    = wr_in && addr_in == 8'h00 && wdata_in[0];
  wire logic [8:0] cpu_gap_next  = cpu_clk_en_out ? 9'h000 : cpu_gap_reg + 9'h001;
  wire logic [8:0] post_gap_next = (fast_rc_post_tick_out || !osc_enable_out.fast_rc_oscillator) ? 9'h000 : post_gap_reg + 9'h001;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cpu_gap_reg  <= 9'h000;
      post_gap_reg <= 9'h000;
      req_hist_reg <= 5'h00;
    end else begin
      cpu_gap_reg  <= cpu_gap_next;
      post_gap_reg <= post_gap_next;
      req_hist_reg <= {req_hist_reg[3:0], req_wr};
    end
  end
  // ----
  // assertions
  // ----
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  chk_rdata_idle: assert property (!rd_in |=> rdata_out == 16'h0000)
    else $error("read data not zero outside a read");
  chk_div_low_zero: assert property (rd_in && addr_in == 8'h02 |=> rdata_out[7:0] == 8'h00)
    else $error("divider low byte not zero");
  chk_trim_high_zero: assert property (rd_in && addr_in == 8'h03 |=> rdata_out[15:6] == 10'h000)
    else $error("trim upper bits not zero");
  chk_trim_out_follows: assert property (wr_in && addr_in == 8'h03 |=> ##1 fast_rc_trim_value_out == $past(wdata_in[5:0], 2))
    else $error("trim output does not follow write");
  chk_cpu_ratio_gap: assert property (cpu_gap_reg <= 9'h080)
    else $error("cpu enable gap above 128");
  chk_post_gap: assert property (post_gap_reg <= 9'h100)
    else $error("postscale tick gap above 256");
  chk_no_reserved_src: assert property (sys_src_sel_out != CSD_SRC_RSVD)
    else $error("reserved source selected");
  chk_disabled_no_busy: assert property (switch_enable_config_in [*6] |-> !$rose(switch_busy_out))
    else $error("switch started while disabled");
  chk_busy_has_cause: assert property ($rose(switch_busy_out) |-> |req_hist_reg[4:1])
    else $error("busy without a request write");
  chk_submode_fixed: assert property (wr_in |=> $stable(primary_submode_out))
    else $error("submode changed by a write");
endmodule
bind csd_clock_switch csd_switch_props chk_i (.*);

// ### verif/tb_top.sv
// self-checking bench for the clock switch block
`timescale 1ns/10ps
module tb_top;
  import csd_pkg::*;
  // ----
  // stimulus and observed ports
  // ----
  logic           clk     = 1'b0;
  logic           rst_n   = 1'b0;
  logic [7:0]     addr    = 8'h00;
  logic [15:0]    wdata   = 16'h0000;
  logic           wr      = 1'b0;
  logic           rd      = 1'b0;
  logic           irq     = 1'b0;
  logic           sw_dis  = 1'b0;
  logic           start_up_timer     = 1'b0;
  logic           lock    = 1'b0;
  logic           new_clk = 1'b0;
  logic [15:0]    rdata;
  csd_src_type    src;
  csd_osc_en_type osc_en;
  logic [1:0]     sub;
  logic [5:0]     trim;
  logic           cpu_en;
  logic           post;
  logic           busy;
  logic [15:0]    rd_last;
  int             err_total = 0;
  int             tests_run = 0;
  int             nc;
  int             np;
  always #2 clk = ~clk;
  // free-running new source, ten system cycles a period
  always #20 new_clk = ~new_clk;
  csd_clock_switch dut (
    .clk_sys_in(clk), .arst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .irq_in(irq), .switch_enable_config_in(sw_dis), .fail_monitor_config_in(1'b1),
    .reset_clock_select_config_in(3'h0), .primary_submode_config_in(2'h1), .watchdog_enable_in(1'b0),
    .start_up_timer_done_in(start_up_timer), .pll_lock_in(lock), .clock_fail_in(1'b0), .new_src_clk_in(new_clk),
    .sys_src_sel_out(src), .osc_enable_out(osc_en), .primary_submode_out(sub),
    .fast_rc_trim_value_out(trim), .cpu_clk_en_out(cpu_en), .fast_rc_post_tick_out(post),
    .switch_busy_out(busy));
  // ----
  // shared tasks
  // ----
  task automatic give_verdict();
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    rd_last = rdata;
    chk(rdata, exp);
  endtask
  task automatic cnt(input int n);
    nc = 0;
    np = 0;
    repeat (n) begin
      @(negedge clk);
      nc += (cpu_en === 1'b1);
      np += (post === 1'b1);
    end
  endtask
  task automatic switch_to(input logic [2:0] s, input logic [7:0] lo);
    wrr(8'h01, 16'h0078);
    wrr(8'h01, 16'h009a);
    wrr(8'h01, {13'h0, s});
    wrr(8'h00, 16'h0046);
    wrr(8'h00, 16'h0057);
    wrr(8'h00, {8'h00, lo});
  endtask
  // busy lags the request by a few edges, so let it rise first
  task automatic wait_idle();
    repeat (4) @(posedge clk);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
    chk({15'h0, busy}, 16'h0000);
    if (busy !== 1'b0)
      give_verdict();
  endtask
  // ----
  // scenarios
  // ----
  task automatic s_regs();
    chk({13'h0, src}, 16'h0000);
    chk({14'h0, sub}, 16'h0001);
    rdchk(8'h02, 16'h0100);
    rdchk(8'h03, 16'h0000);
    rdchk(8'h10, 16'h0000);
    rdchk(8'h00, 16'h0000);
    wrr(8'h02, 16'hffff);
    rdchk(8'h02, 16'hff00);
    wrr(8'h03, 16'hffff);
    rdchk(8'h03, 16'h003f);
    chk({10'h0, trim}, 16'h003f);
    wrr(8'h03, 16'h0020);
    rdchk(8'h03, 16'h0020);
  endtask
  task automatic s_ratio();
    for (int n = 0; n < 8; n++) begin
      wrr(8'h02, {1'b0, 3'(n), 1'b1, 3'(n), 8'h00});
      cnt(300);
      cnt(256);
      chk(16'(nc), 16'(256 >> n));
      chk(16'(np), 16'(n == 7 ? 1 : 256 >> n));
    end
    wrr(8'h02, 16'h7000);
    cnt(8);
    cnt(256);
    chk(16'(nc), 16'h0100);
  endtask
  task automatic s_roi();
    wrr(8'h02, 16'hbb00);
    @(posedge clk) irq <= 1'b1;
    @(posedge clk) irq <= 1'b0;
    rdchk(8'h02, 16'hb300);
    cnt(16);
    chk(16'(nc), 16'h0010);
    wrr(8'h02, 16'h3b00);
    @(posedge clk) irq <= 1'b1;
    @(posedge clk) irq <= 1'b0;
    rdchk(8'h02, 16'h3b00);
  endtask
  task automatic s_switch();
    wrr(8'h02, 16'h0100);
    wrr(8'h01, 16'h0003);
    rdchk(8'h00, 16'h0000);
    wrr(8'h01, 16'h0078);
    wrr(8'h01, 16'h009a);
    rdchk(8'h00, 16'h0000);
    wrr(8'h01, 16'h0003);
    rdchk(8'h00, 16'h0000);
    switch_to(3'h0, 8'h01);
    wait_idle();
    rdchk(8'h00, 16'h0000);
    switch_to(3'h3, 8'h03);
    rdchk(8'h00, 16'h0303);
    cnt(40);
    chk(16'(nc), 16'h0028);
    chk({15'h0, busy}, 16'h0001);
    @(posedge clk) start_up_timer <= 1'b1;
    cnt(40);
    chk({15'h0, busy}, 16'h0001);
    chk({13'h0, src}, 16'h0000);
    @(posedge clk) lock <= 1'b1;
    cnt(60);
    chk({15'h0, busy}, 16'h0001);
    wait_idle();
    cnt(4);
    chk({13'h0, src}, 16'h0003);
    chk({11'h0, osc_en}, 16'h000e);
    rdchk(8'h00, 16'h3322);
    @(posedge clk) sw_dis <= 1'b1;
    cnt(10);
    chk({13'h0, src}, 16'h0000);
    switch_to(3'h2, 8'h01);
    cnt(10);
    chk({15'h0, busy}, 16'h0000);
    rdchk(8'h02, 16'h0100);
    rdchk(8'h00, 16'h0200);
    chk(rd_last & 16'h0001, 16'h0000);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    s_regs();
    s_ratio();
    s_roi();
    s_switch();
    give_verdict();
  end
endmodule
